// ==== lbps_sequencer.sv ====
`timescale 1ns/100ps
// Contract
// - buck enable follows buck rail enable level
// - negative pump waits delay from buck pgood
// - boost needs buck pgood and boost enable
// - positive delay expiry enables pump and amplifiers
// - gate shaping needs positive pgood and enable
// - over-temperature shuts down, restarts when cleared
// - undervoltage holds every converter and pump off
// - late boost enable restarts positive delay while the positive pump is still off
module lbps_sequencer (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// pins, comparators and delay timer expiry, all asynchronous
	input wire lbps_pkg::lbps_sense_t sense_i,
	// converter enables and delay timer controls
	output lbps_pkg::lbps_enables_t enables_o
);
	import lbps_pkg::*;

	// whole state of the sequencer
	typedef struct packed {
		lbps_seq_state_t fsm;
		logic boost_enable_prev;   // last settled boost enable, for edge detect
		lbps_enables_t en;
	} lbps_core_t;

	localparam lbps_core_t LBPS_CORE_RST = '{
		fsm: LBPS_ST_RST,
		boost_enable_prev: 1'b0,
		en: LBPS_ENABLES_RST
	};

	lbps_core_t q;
	lbps_core_t d;

	logic [LBPS_SENSE_W-1:0] sense_sync;
	lbps_sense_t s;
	logic shutdown;
	logic boost_rise;
	logic pos_restart;

	// every input arrives from analogue comparators or pins: settle it first
	lbps_sync #(
		.W(LBPS_SENSE_W)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i(sense_i),
		.sync_o(sense_sync)
	);

	assign s = lbps_sense_t'(sense_sync);

	// any shutdown cause collapses the whole sequence
	assign shutdown = !s.buck_rail_enable | s.over_temp | s.uvlo;

	// boost enable edge, only meaningful once buck power good has been seen
	assign boost_rise = s.boost_rail_enable & !q.boost_enable_prev;

	// a late boost enable re-times the positive delay, unless the pump already runs
	assign pos_restart = boost_rise & !q.en.pos_pump_en;

	// next state
	always_comb begin
		d = q;
		d.boost_enable_prev = s.boost_rail_enable;
		if (shutdown) begin
			// drop every enable and discharge both timers, so a restart
			// always starts from a clean sequence
			d.fsm = LBPS_ST_OFF;
			d.en = LBPS_ENABLES_RST;
		end else begin
			unique case (q.fsm)
				LBPS_ST_OFF: begin
					// enable high and no fault: start the buck again; this is
					// also the automatic restart after a thermal event
					d.en = LBPS_ENABLES_RST;
					d.en.buck_en = 1'b1;
					d.fsm = LBPS_ST_WAIT_PG;
				end
				LBPS_ST_WAIT_PG: begin
					d.en = LBPS_ENABLES_RST;
					d.en.buck_en = 1'b1;
					if (s.buck_pgood) begin
						// both delays are timed from buck power good
						d.fsm = LBPS_ST_RUN;
						d.en.negative_pump_delay_run = 1'b1;
						d.en.positive_pump_delay_run = 1'b1;
					end
				end
				LBPS_ST_RUN: begin
					d.en.buck_en = 1'b1;
					// buck pgood is latched by being in this state; boost
					// follows its enable level from here on
					d.en.boost_en = s.boost_rail_enable;
					d.en.negative_pump_delay_run = 1'b1;
					// timer expiry only counts while the timer is running
					if (q.en.negative_pump_delay_run && s.negative_pump_delay_done) begin
						d.en.neg_pump_en = 1'b1;
					end
					// one low cycle on the run line discharges the capacitor
					d.en.positive_pump_delay_run = !pos_restart;
					if (q.en.positive_pump_delay_run && s.positive_pump_delay_done &&
						!pos_restart) begin
						d.en.pos_pump_en = 1'b1;
						d.en.amp_en = 1'b1;
					end
					// shaping follows its enable and the pump pgood as levels
					d.en.gate_shaping_en = q.en.pos_pump_en & s.pos_pump_pgood &
						s.shaping_enable_input;
				end
				default: begin
					// unused code: fall back to off, enables cleared
					d.fsm = LBPS_ST_OFF;
					d.en = LBPS_ENABLES_RST;
				end
			endcase
		end
	end

	// state register; reset is the undervoltage lockout release
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			q <= LBPS_CORE_RST;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flip-flops, no glitches toward the power stages
	assign enables_o = q.en;
endmodule

// ==== lbps_pkg.sv ====
// shared types and constants for the display bias power sequencer
package lbps_pkg;

	// sequencer states, gray coded along off -> wait -> run
	typedef enum logic [1:0] {
		LBPS_ST_OFF = 2'h0,
		LBPS_ST_WAIT_PG = 2'h1,
		LBPS_ST_RUN = 2'h3
	} lbps_seq_state_t;

	// inputs from pins, comparators and the capacitor delay timers
	typedef struct packed {
		logic buck_rail_enable;      // buck converter and negative pump enable pin
		logic boost_rail_enable;     // boost converter block enable pin
		logic shaping_enable_input;  // gate shaping block enable pin
		logic buck_pgood;            // step-down converter power good
		logic pos_pump_pgood;        // positive charge pump power good
		logic negative_pump_delay_done; // negative pump delay capacitor reached reference
		logic positive_pump_delay_done; // positive pump delay capacitor reached reference
		logic over_temp;             // thermal shutdown comparator
		logic uvlo;                  // input supply below lockout level
	} lbps_sense_t;

	// enables to the converters and controls to the delay timers
	typedef struct packed {
		logic buck_en;
		logic boost_en;
		logic neg_pump_en;           // negative_gate_rail charge pump
		logic pos_pump_en;           // positive_gate_rail charge pump
		logic amp_en;
		logic gate_shaping_en;       // gate_shaping_block
		logic negative_pump_delay_run; // low holds the timer capacitor discharged
		logic positive_pump_delay_run;
	} lbps_enables_t;

	localparam int LBPS_SENSE_W = $bits(lbps_sense_t);

	// values after reset
	localparam lbps_enables_t LBPS_ENABLES_RST = '0;
	localparam lbps_seq_state_t LBPS_ST_RST = LBPS_ST_OFF;
	localparam logic [LBPS_SENSE_W-1:0] LBPS_SYNC_RST = '0;

endpackage

// ==== lbps_sync.sv ====
`timescale 1ns/100ps
// two flip-flop synchroniser for a bundle of asynchronous levels
module lbps_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// asynchronous levels in, settled levels out
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} lbps_sync_state_t;

	lbps_sync_state_t q;
	lbps_sync_state_t d;

	// the first stage feeds only the second, nothing else looks at it
	always_comb begin
		d = q;
		d.meta = async_i;
		d.stable = q.meta;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_o = q.stable;
endmodule

// ==== lbps_sequencer_sva.sv ====
`timescale 1ns/100ps
// port checks; a sense level reaches the outputs three edges later
module lbps_chk (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// watched ports
	input wire lbps_pkg::lbps_sense_t sense_i,
	input wire lbps_pkg::lbps_enables_t enables_o
);
	import lbps_pkg::*;
	lbps_sense_t s;
	lbps_enables_t e;
	// short aliases keep the properties readable
	assign s = sense_i;
	assign e = enables_o;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_off; !s.buck_rail_enable |-> ##3 e == '0; endproperty
	a_off: assert property (p_off) else $error("enable low");
	property p_flt; s.over_temp || s.uvlo |-> ##3 e == '0; endproperty
	a_flt: assert property (p_flt) else $error("fault");
	property p_neg; $rose(e.neg_pump_en) |-> $past(s.negative_pump_delay_done, 3); endproperty
	a_neg: assert property (p_neg) else $error("neg pump");
	property p_bst; $rose(e.boost_en) |-> $past(s.boost_rail_enable, 3); endproperty
	a_bst: assert property (p_bst) else $error("boost");
	property p_pos; $rose(e.pos_pump_en) |-> e.amp_en; endproperty
	a_pos: assert property (p_pos) else $error("pos pump");
	property p_gs; $rose(e.gate_shaping_en) |-> $past(s.pos_pump_pgood, 3); endproperty
	a_gs: assert property (p_gs) else $error("shaping");
	// late boost enable with the positive pump still off drops the positive timer for exactly one cycle
	property p_late; $rose(s.boost_rail_enable) ##2 e.positive_pump_delay_run && !e.pos_pump_en
		|-> ##1 !e.positive_pump_delay_run ##1 e.positive_pump_delay_run; endproperty
	a_late: assert property (p_late) else $error("late boost");
	property p_rst; $fell(s.over_temp) && s.buck_rail_enable && !s.uvlo |-> ##[3:4] e.buck_en;
	endproperty
	a_rst: assert property (p_rst) else $error("restart");
	c_gs: cover property ($rose(e.gate_shaping_en));
	c_off: cover property ($fell(e.buck_en));
	c_late: cover property ($fell(e.positive_pump_delay_run) && e.buck_en);
endmodule
bind lbps_sequencer lbps_chk lbps_chk_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.sense_i(sense_i), .enables_o(enables_o));

// ==== lbps_plant.sv ====
`timescale 1ns/100ps
// converters and delay capacitors: each flag rises D cycles after its enable
module lbps_plant #(
	parameter int D = 20
) (
	// clock
	input wire logic core_clk_i,
	// enables in; buck pgood, pos pgood, neg done, pos done out
	input wire lbps_pkg::lbps_enables_t en_i,
	output logic [3:0] st_o = 4'h0
);
	import lbps_pkg::*;
	logic [3:0] src;
	int cnt [4] = '{default: 0};
	// a dropped enable clears the counter on the next edge, so done outlives run by one cycle
	assign src = {en_i.buck_en, en_i.pos_pump_en,
		en_i.negative_pump_delay_run, en_i.positive_pump_delay_run};
	// saturating charge counters
	always @(posedge core_clk_i) begin
		for (int k = 0; k < 4; k++) begin
			cnt[k] <= src[k] ? ((cnt[k] < D) ? cnt[k] + 1 : D) : 0;
			st_o[k] <= src[k] && cnt[k] >= D - 1;
		end
	end
endmodule

// ==== test_lbps_sequencer.sv ====
`timescale 1ns/100ps
module test_lbps_sequencer;
	import lbps_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] drv = 5'h00;
	logic [3:0] st;
	lbps_enables_t en;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	// pins in, expected enables out
	logic [12:0] rows [8] = '{{5'h1c, 8'hff}, {5'h18, 8'hfb}, {5'h10, 8'hbb}, {5'h12, 8'h00},
		{5'h10, 8'hbb}, {5'h11, 8'h00}, {5'h00, 8'h00}, {5'h1c, 8'hff}};
	lbps_sequencer lbps_sequencer_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.sense_i({drv[4:2], st, drv[1:0]}), .enables_o(en));
	lbps_plant #(.D(20)) lbps_plant_inst (.core_clk_i(core_clk_i), .en_i(en), .st_o(st));
	always #10 core_clk_i = ~core_clk_i;
	task automatic chk(string n, logic [7:0] x, logic [7:0] g);
		checked++;
		if (g !== x) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic finish_test();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// hang guard well above the expected run length
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			finish_test();
		end
	end
	initial begin
		repeat (20) @(posedge core_clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			drv <= rows[i][12:8];
			repeat (120) @(posedge core_clk_i);
			#1 chk("row", rows[i][7:0], en);
			$display("row %0d done", i);
		end
		rst_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1 chk("reset", 8'h00, en);
		$display("reset done");
		rst_i <= 1'b0;
		drv <= 5'h10;
		// late boost: wait for the timers, then raise the boost pin
		for (int k = 0; k < 200 && en.negative_pump_delay_run !== 1'b1; k++) @(posedge core_clk_i);
		repeat (10) @(posedge core_clk_i);
		// boost pin is bit 3; the positive delay must restart from this edge
		drv <= 5'h18;
		repeat (20) @(posedge core_clk_i);
		#1 chk("late", 8'h00, {7'h00, en.pos_pump_en});
		repeat (30) @(posedge core_clk_i);
		#1 chk("late", 8'h01, {7'h00, en.pos_pump_en});
		$display("late boost done");
		finish_test();
	end
endmodule
